// File: cbt_defs.vh
// constants for the can bit timing, flag acknowledge, wake-up and mode logic
// assumes a single 100 MHz clock and that all quantum sources arrive as clk enables
// How it works
// - quantum tick is selected source divided by prescaler
// - sync segment lasts one quantum, or at most one after a hard resync
// - segment one programmable from 4 to 16 quanta
// - segment two programmable from 2 to 8 quanta
// - no clock generator means oscillator source only
// - acceptance control sets filter size and count
// - mask bit zero makes identifier bit compared
// - interrupt pending while any enabled flag set
// - writing one clears flag, zero leaves it
// - clear ignored while setting condition still holds
// - wake-up interrupt lets low-power states end
// - wake-up armed only if sleep, enables all set
// - sleep acknowledge waits for an idle bus, or is given at once in init mode
// - init acknowledge follows request after sleep handshake, or at once while disabled
`ifndef CBT_DEFS_VH
`define CBT_DEFS_VH

// ----------------------------------------------------------------
// field widths
// ----------------------------------------------------------------
`define CBT_PRESC_W 6
`define CBT_TIME_SEGMENT_ONE_W 4
`define CBT_TIME_SEGMENT_TWO_W 3
`define CBT_RXFLAG_W 8
`define CBT_TXFLAG_W 3
`define CBT_ACC_W 2

// ----------------------------------------------------------------
// segment limits, encoded as length minus one
// ----------------------------------------------------------------
`define CBT_TIME_SEGMENT_ONE_MIN 4'h3
`define CBT_TIME_SEGMENT_TWO_MIN 3'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CBT_PRESC_RST 6'h00
`define CBT_TIME_SEGMENT_ONE_RST 4'h3
`define CBT_TIME_SEGMENT_TWO_RST 3'h1
`define CBT_ACC_RST 2'h0
`define CBT_MASK_RST 32'hffffffff
`define CBT_CODE_RST 32'h00000000

// ----------------------------------------------------------------
// acceptance filter layouts
// ----------------------------------------------------------------
`define CBT_ACC_ONE32 2'h0
`define CBT_ACC_TWO16 2'h1
`define CBT_ACC_FOUR8 2'h2
`define CBT_ACC_CLOSED 2'h3

// ----------------------------------------------------------------
// bus idle detection: recessive bits in a row
// ----------------------------------------------------------------
`define CBT_IDLE_BITS 4'hb

`endif

// File: cbt_tq_div.v
// quantum tick divider
// assumes srcTick is a one-cycle enable on clk from the chosen can clock source
`timescale 1ns/100ps
`include "cbt_defs.vh"

module cbt_tq_div (
  input wire clk, // system clock
  input wire rstN, // synchronised active-low reset
  input wire run, // divider running
  input wire srcTick, // source clock enable
  input wire [`CBT_PRESC_W-1:0] presc, // prescaler value minus one
  output reg tqTick // one quantum per pulse
);

  reg [`CBT_PRESC_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // divide source ticks by presc+1
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q <= {`CBT_PRESC_W{1'b0}};
      tqTick <= 1'b0;
    end else if (!run) begin
      cnt_q <= {`CBT_PRESC_W{1'b0}};
      tqTick <= 1'b0;
    end else if (srcTick) begin
      if (cnt_q == presc) begin
        cnt_q <= {`CBT_PRESC_W{1'b0}};
        tqTick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tqTick <= 1'b0;
      end
    end else begin
      tqTick <= 1'b0;
    end
  end

endmodule

// File: cbt_bit_tmr.v
// bit timer: walks sync segment, segment one and segment two in quanta
// assumes rxIn is already synchronised to clk
`timescale 1ns/100ps
`include "cbt_defs.vh"

module cbt_bit_tmr (
  input wire clk, // system clock
  input wire rstN, // synchronised active-low reset
  input wire run, // timer running
  input wire tqTick, // quantum enable
  input wire [`CBT_TIME_SEGMENT_ONE_W-1:0] time_segment_one, // segment one length minus one
  input wire [`CBT_TIME_SEGMENT_TWO_W-1:0] time_segment_two, // segment two length minus one
  input wire rxIn, // synchronised bus level
  output reg samplePulse, // one-cycle pulse at the sample point
  output reg sampleBit // bus level taken at the sample point
);

  reg [4:0] tqCnt_q;
  reg rxLast_q;
  wire [4:0] seg1End;
  wire [4:0] bitEnd;
  wire fallEdge;

  // quantum 0 is the sync segment, then segment one, then segment two
  assign seg1End = {1'b0, time_segment_one} + 5'h1;
  assign bitEnd = seg1End + {2'b00, time_segment_two} + 5'h1;
  assign fallEdge = rxLast_q & ~rxIn;

  // ----------------------------------------------------------------
  // quantum counter with hard resync on a recessive to dominant edge
  // ----------------------------------------------------------------
  // a full resync keeps the logic small; it trades phase accuracy on
  // late edges for not needing a jump-width register
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tqCnt_q <= 5'h00;
      rxLast_q <= 1'b1;
      samplePulse <= 1'b0;
      sampleBit <= 1'b1;
    end else begin
      rxLast_q <= rxIn;
      samplePulse <= 1'b0;
      if (!run) begin
        tqCnt_q <= 5'h00;
      end else if (fallEdge && tqCnt_q != 5'h00) begin
        tqCnt_q <= 5'h00;
      end else if (tqTick) begin
        if (tqCnt_q == bitEnd) begin
          tqCnt_q <= 5'h00;
        end else begin
          tqCnt_q <= tqCnt_q + 5'h1;
        end
        if (tqCnt_q == seg1End) begin
          samplePulse <= 1'b1;
          sampleBit <= rxIn;
        end
      end
    end
  end

endmodule

// File: cbt_top.v
// can bit timing, flag acknowledge, wake-up and mode sequencing
// assumes flag conditions, source ticks and config values come from clk logic;
// only the bus receive pin and the reset input are asynchronous
`timescale 1ns/100ps
`include "cbt_defs.vh"

module cbt_top #(
  parameter HAS_CLK_GEN = 1 // 0: no clock generator, oscillator source only
) (
  input wire clk, // system clock
  input wire resetn, // asynchronous active-low reset
  input wire moduleEnableBit, // module enable
  input wire initModeRequest, // request initialization mode
  input wire sleepRequest, // request sleep mode
  input wire wakeupEnable, // wake-up on bus activity allowed
  input wire wakeupInterruptEnable, // wake-up interrupt enable
  input wire clkSrcBus, // 1 selects bus clock as quantum source
  input wire oscTick, // oscillator clock enable
  input wire busTick, // bus clock enable
  input wire cfgWrite, // configuration write strobe
  input wire [`CBT_PRESC_W-1:0] cfgPresc, // prescaler minus one
  input wire [`CBT_TIME_SEGMENT_ONE_W-1:0] cfgTseg1, // segment one minus one
  input wire [`CBT_TIME_SEGMENT_TWO_W-1:0] cfgTseg2, // segment two minus one
  input wire [`CBT_ACC_W-1:0] cfgAccCtrl, // acceptance control layout
  input wire [31:0] cfgAccCode, // acceptance code bytes
  input wire [31:0] cfgAccMask, // acceptance mask bytes
  input wire [`CBT_RXFLAG_W-1:0] rxFlagCond, // receiver flag set conditions
  input wire [`CBT_TXFLAG_W-1:0] txFlagCond, // transmitter flag set conditions
  input wire rxFlagWrite, // receiver flag register write strobe
  input wire [`CBT_RXFLAG_W-1:0] rxFlagData, // write data, 1 clears
  input wire txFlagWrite, // transmitter flag register write strobe
  input wire [`CBT_TXFLAG_W-1:0] txFlagData, // write data, 1 clears
  input wire [`CBT_RXFLAG_W-1:0] rxIrqEnable, // receiver interrupt enables
  input wire [`CBT_TXFLAG_W-1:0] txIrqEnable, // transmitter interrupt enables
  input wire lowPower, // chip entering stop or wait
  input wire wakeupClear, // write-one clear of the wake-up flag
  input wire [31:0] rxId, // identifier to filter
  input wire rxIdValid, // identifier strobe
  input wire canRx, // bus receive pin
  output reg canTx, // bus transmit pin, recessive here
  output reg initModeAcknowledge, // initialization mode active
  output reg sleepAcknowledge, // sleep mode active
  output reg busIdle, // bus seen idle
  output reg [`CBT_RXFLAG_W-1:0] receiverFlagReg, // receiver flags
  output reg [`CBT_TXFLAG_W-1:0] transmitterFlagReg, // transmitter flags
  output reg rxIrq, // receiver interrupt request
  output reg txIrq, // transmitter interrupt request
  output reg wakeupIrq, // wake-up interrupt request
  output reg idHit, // identifier accepted
  output reg [2:0] idHitIdx, // index of the matching filter
  output reg sampleOut // last sampled bus level
);

  // ----------------------------------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------------------------------
  reg rstMeta_q;
  reg rstN;
  reg rxMeta_q;
  reg rxSync_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN <= rstMeta_q;
    end
  end

  // only rxSync_q is read by logic
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else begin
      rxMeta_q <= canRx;
      rxSync_q <= rxMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a mask bit of zero forces that identifier bit to match the code
  function byteMatch;
    input [7:0] id;
    input [7:0] code;
    input [7:0] mask;
    begin
      byteMatch = ~|((id ^ code) & ~mask);
    end
  endfunction

  // flag update: set wins, write-one clear ignored while condition holds
  function [7:0] flagNext;
    input [7:0] cur;
    input [7:0] cond;
    input wr;
    input [7:0] data;
    begin
      flagNext = (cur & ~({8{wr}} & data & ~cond)) | cond;
    end
  endfunction

  // ----------------------------------------------------------------
  // configuration registers, writable only in initialization mode
  // ----------------------------------------------------------------
  reg [`CBT_PRESC_W-1:0] presc_q;
  reg [`CBT_TIME_SEGMENT_ONE_W-1:0] time_segment_one_q;
  reg [`CBT_TIME_SEGMENT_TWO_W-1:0] time_segment_two_q;
  reg [`CBT_ACC_W-1:0] accCtrl_q;
  reg [31:0] accCode_q;
  reg [31:0] accMask_q;
  reg srcBus_q;

  // short segment requests are clamped to the legal minimum instead of
  // refused, so the timer never runs with a degenerate bit
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      presc_q <= `CBT_PRESC_RST;
      time_segment_one_q <= `CBT_TIME_SEGMENT_ONE_RST;
      time_segment_two_q <= `CBT_TIME_SEGMENT_TWO_RST;
      accCtrl_q <= `CBT_ACC_RST;
      accCode_q <= `CBT_CODE_RST;
      accMask_q <= `CBT_MASK_RST;
      srcBus_q <= 1'b0;
    end else if (cfgWrite && initModeAcknowledge) begin
      presc_q <= cfgPresc;
      time_segment_one_q <= (cfgTseg1 < `CBT_TIME_SEGMENT_ONE_MIN) ? `CBT_TIME_SEGMENT_ONE_MIN : cfgTseg1;
      time_segment_two_q <= (cfgTseg2 < `CBT_TIME_SEGMENT_TWO_MIN) ? `CBT_TIME_SEGMENT_TWO_MIN : cfgTseg2;
      accCtrl_q <= cfgAccCtrl;
      accCode_q <= cfgAccCode;
      accMask_q <= cfgAccMask;
      srcBus_q <= (HAS_CLK_GEN != 0) ? clkSrcBus : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // quantum generation and bit timing
  // ----------------------------------------------------------------
  wire srcTick;
  wire tqTick;
  wire samplePulse;
  wire sampleBit;
  wire timerRun;

  assign srcTick = srcBus_q ? busTick : oscTick;
  assign timerRun = moduleEnableBit & ~initModeAcknowledge;

  cbt_tq_div u_div (
    .clk(clk),
    .rstN(rstN),
    .run(timerRun),
    .srcTick(srcTick),
    .presc(presc_q),
    .tqTick(tqTick)
  );

  cbt_bit_tmr u_tmr (
    .clk(clk),
    .rstN(rstN),
    .run(timerRun),
    .tqTick(tqTick),
    .time_segment_one(time_segment_one_q),
    .time_segment_two(time_segment_two_q),
    .rxIn(rxSync_q),
    .samplePulse(samplePulse),
    .sampleBit(sampleBit)
  );

  // ----------------------------------------------------------------
  // bus idle detection: a run of recessive samples
  // ----------------------------------------------------------------
  reg [3:0] recCnt_q;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      recCnt_q <= 4'h0;
      busIdle <= 1'b0;
      sampleOut <= 1'b1;
    end else if (!timerRun) begin
      recCnt_q <= 4'h0;
      busIdle <= 1'b0;
    end else if (samplePulse) begin
      sampleOut <= sampleBit;
      if (!sampleBit) begin
        recCnt_q <= 4'h0;
        busIdle <= 1'b0;
      end else if (recCnt_q == `CBT_IDLE_BITS - 4'h1) begin
        busIdle <= 1'b1;
      end else begin
        recCnt_q <= recCnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode handshakes
  // ----------------------------------------------------------------
  // sleep is entered on an idle bus, or at once in initialization mode, so a frame is never cut;
  // init is entered from sleep, or at once while the module is disabled
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sleepAcknowledge <= 1'b0;
      initModeAcknowledge <= 1'b1;
      canTx <= 1'b1;
    end else begin
      canTx <= 1'b1;
      if (!sleepRequest) begin
        sleepAcknowledge <= 1'b0;
      end else if (busIdle || initModeAcknowledge) begin
        sleepAcknowledge <= 1'b1;
      end
      if (!initModeRequest && moduleEnableBit) begin
        initModeAcknowledge <= 1'b0;
      end else if (initModeRequest && (sleepAcknowledge || !moduleEnableBit)) begin
        initModeAcknowledge <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver and transmitter flags with interrupt requests
  // ----------------------------------------------------------------
  wire [7:0] rxFlagNext;
  wire [7:0] txFlagNext;

  assign rxFlagNext = flagNext(receiverFlagReg, rxFlagCond, rxFlagWrite, rxFlagData);
  assign txFlagNext = flagNext({5'h00, transmitterFlagReg}, {5'h00, txFlagCond},
                               txFlagWrite, {5'h00, txFlagData});

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      receiverFlagReg <= {`CBT_RXFLAG_W{1'b0}};
      transmitterFlagReg <= {`CBT_TXFLAG_W{1'b0}};
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
    end else begin
      receiverFlagReg <= rxFlagNext;
      transmitterFlagReg <= txFlagNext[`CBT_TXFLAG_W-1:0];
      rxIrq <= |(rxFlagNext & rxIrqEnable);
      txIrq <= |(txFlagNext[`CBT_TXFLAG_W-1:0] & txIrqEnable);
    end
  end

  // ----------------------------------------------------------------
  // wake-up from stop or wait
  // ----------------------------------------------------------------
  // armed on the way into low power; a dominant level on the bus then
  // raises the request, which stays until cleared with a write of one
  reg wakeArmed_q;
  reg lowPowerLast_q;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wakeArmed_q <= 1'b0;
      lowPowerLast_q <= 1'b0;
      wakeupIrq <= 1'b0;
    end else begin
      lowPowerLast_q <= lowPower;
      if (lowPower && !lowPowerLast_q) begin
        wakeArmed_q <= sleepRequest & sleepAcknowledge &
                       wakeupEnable & wakeupInterruptEnable;
      end else if (!lowPower) begin
        wakeArmed_q <= 1'b0;
      end
      if (wakeArmed_q && !rxSync_q) begin
        wakeupIrq <= 1'b1;
      end else if (wakeupClear) begin
        wakeupIrq <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // identifier acceptance filter
  // ----------------------------------------------------------------
  wire [3:0] hit8;
  wire [1:0] hit16;
  wire hit32;

  // every filter looks at the leading identifier bits
  assign hit8[0] = byteMatch(rxId[31:24], accCode_q[7:0], accMask_q[7:0]);
  assign hit8[1] = byteMatch(rxId[31:24], accCode_q[15:8], accMask_q[15:8]);
  assign hit8[2] = byteMatch(rxId[31:24], accCode_q[23:16], accMask_q[23:16]);
  assign hit8[3] = byteMatch(rxId[31:24], accCode_q[31:24], accMask_q[31:24]);
  assign hit16[0] = byteMatch(rxId[31:24], accCode_q[15:8], accMask_q[15:8]) &
                    byteMatch(rxId[23:16], accCode_q[7:0], accMask_q[7:0]);
  assign hit16[1] = byteMatch(rxId[31:24], accCode_q[31:24], accMask_q[31:24]) &
                    byteMatch(rxId[23:16], accCode_q[23:16], accMask_q[23:16]);
  assign hit32 = byteMatch(rxId[31:24], accCode_q[31:24], accMask_q[31:24]) &
                 byteMatch(rxId[23:16], accCode_q[23:16], accMask_q[23:16]) &
                 byteMatch(rxId[15:8], accCode_q[15:8], accMask_q[15:8]) &
                 byteMatch(rxId[7:0], accCode_q[7:0], accMask_q[7:0]);

  // lowest-numbered matching filter wins
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      idHit <= 1'b0;
      idHitIdx <= 3'h0;
    end else if (rxIdValid) begin
      case (accCtrl_q)
        `CBT_ACC_ONE32: begin
          idHit <= hit32;
          idHitIdx <= 3'h0;
        end
        `CBT_ACC_TWO16: begin
          idHit <= |hit16;
          idHitIdx <= hit16[0] ? 3'h0 : 3'h1;
        end
        `CBT_ACC_FOUR8: begin
          idHit <= |hit8;
          idHitIdx <= hit8[0] ? 3'h0 : hit8[1] ? 3'h1 : hit8[2] ? 3'h2 : 3'h3;
        end
        default: begin
          idHit <= 1'b0;
          idHitIdx <= 3'h0;
        end
      endcase
    end else begin
      idHit <= 1'b0;
    end
  end

endmodule

// File: cbt_top_chk.sv
// assertions watching the ports of the can timing and mode block
// assumes it is bound to cbt_top; checks wait out the two-flop reset release
`timescale 1ns/100ps
`include "cbt_defs.vh"

module cbt_top_chk (
  input logic clk, // clock
  input logic resetn, // async reset
  input logic moduleEnableBit, // enable
  input logic initModeRequest, // init request
  input logic sleepRequest, // sleep request
  input logic wakeupEnable, // wake option
  input logic wakeupInterruptEnable, // wake irq enable
  input logic lowPower, // stop or wait
  input logic [`CBT_RXFLAG_W-1:0] rxFlagCond, // rx set
  input logic [`CBT_TXFLAG_W-1:0] txFlagCond, // tx set
  input logic rxFlagWrite, // rx clear strobe
  input logic [`CBT_RXFLAG_W-1:0] rxFlagData, // rx clear bits
  input logic txFlagWrite, // tx clear strobe
  input logic [`CBT_TXFLAG_W-1:0] txFlagData, // tx clear bits
  input logic [`CBT_RXFLAG_W-1:0] rxIrqEnable, // rx enables
  input logic [`CBT_TXFLAG_W-1:0] txIrqEnable, // tx enables
  input logic rxIdValid, // id strobe
  input logic initModeAcknowledge, // init ack
  input logic sleepAcknowledge, // sleep ack
  input logic busIdle, // bus idle
  input logic [`CBT_RXFLAG_W-1:0] receiverFlagReg, // rx flags
  input logic [`CBT_TXFLAG_W-1:0] transmitterFlagReg, // tx flags
  input logic rxIrq, // rx irq
  input logic txIrq, // tx irq
  input logic wakeupIrq, // wake irq
  input logic idHit // filter hit
);
  logic [1:0] age_q;
  logic live, lpPrev_q, armed_q;

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // outputs are still in reset for two edges after release, so hold off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      age_q <= 2'h0;
      lpPrev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (!live) age_q <= age_q + 2'h1;
      lpPrev_q <= lowPower;
      if (lowPower && !lpPrev_q)
        armed_q <= sleepRequest && sleepAcknowledge && wakeupEnable && wakeupInterruptEnable;
    end
  end
  assign live = (age_q == 2'h3);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !live);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_rx_flag_set: assert property (
    rxFlagCond != 0 |=> (receiverFlagReg & $past(rxFlagCond)) == $past(rxFlagCond))
    else $error("rx flag missed its condition");
  a_rx_flag_clear: assert property (
    rxFlagWrite |=> receiverFlagReg == (($past(receiverFlagReg) & ~$past(rxFlagData))
    | $past(rxFlagCond))) else $error("rx flag clear wrong");
  a_tx_flag_clear: assert property (
    txFlagWrite |=> transmitterFlagReg == (($past(transmitterFlagReg) & ~$past(txFlagData))
    | $past(txFlagCond))) else $error("tx flag clear wrong");
  a_rx_irq_level: assert property (
    $stable(rxIrqEnable) |-> rxIrq == |(receiverFlagReg & rxIrqEnable))
    else $error("rx irq does not follow flags");
  a_tx_irq_level: assert property (
    $stable(txIrqEnable) |-> txIrq == |(transmitterFlagReg & txIrqEnable))
    else $error("tx irq does not follow flags");
  a_sleep_needs_idle: assert property (
    $rose(sleepAcknowledge) |-> $past(sleepRequest && (busIdle || initModeAcknowledge)))
    else $error("sleep ack without idle bus");
  a_sleep_grant: assert property (
    sleepRequest && busIdle |=> sleepAcknowledge) else $error("sleep ack late");
  a_init_order: assert property (
    $rose(initModeAcknowledge) |->
    $past(initModeRequest && (sleepAcknowledge || !moduleEnableBit)))
    else $error("init ack out of order");
  a_init_grant: assert property (
    initModeRequest && sleepAcknowledge |=> initModeAcknowledge) else $error("init ack late");
  a_init_leave: assert property (
    !initModeRequest && moduleEnableBit && initModeAcknowledge |=> !initModeAcknowledge)
    else $error("init mode not left");
  a_wake_armed: assert property (
    $rose(wakeupIrq) |-> armed_q && $past(lowPower)) else $error("wake irq while not armed");
  a_hit_cause: assert property (
    idHit |-> $past(rxIdValid)) else $error("filter hit without id");

  c_sleep_wait: cover property (sleepRequest && !busIdle ##1 !sleepAcknowledge);
  c_wake: cover property ($rose(wakeupIrq));
  c_clear_refused: cover property (rxFlagWrite && (rxFlagData & rxFlagCond) != 0);
  c_hit: cover property (idHit);
endmodule

bind cbt_top cbt_top_chk u_chk (.*);

// File: cbt_bus_node.sv
// far side of the can bus: transceiver plus the other nodes
// assumes a wired-and bus pulled recessive (high) by its termination
`timescale 1ns/100ps

module cbt_bus_node (
  input logic canTx, // our transmit level
  input logic domReq, // another node drives dominant
  output logic canRx // resolved bus level
);
  // any dominant driver wins; a released bus returns to recessive
  assign canRx = canTx & ~domReq;
endmodule

// File: cbt_top_tb.sv
// self-checking bench for the can timing, flag and mode block
// assumes one 100 MHz clock; inputs change on the falling edge
`timescale 1ns/100ps
`include "cbt_defs.vh"

module cbt_top_tb;
  logic clk = 1'b0, resetn = 1'b0, moduleEnableBit = 1'b0, initModeRequest = 1'b1;
  logic sleepRequest = 1'b0, wakeupEnable = 1'b0, wakeupInterruptEnable = 1'b0;
  logic clkSrcBus = 1'b0, oscTick = 1'b1, busTick = 1'b0, cfgWrite = 1'b0, domReq = 1'b0;
  logic [`CBT_PRESC_W-1:0] cfgPresc = 6'h00;
  logic [`CBT_TIME_SEGMENT_ONE_W-1:0] cfgTseg1 = 4'h3;
  logic [`CBT_TIME_SEGMENT_TWO_W-1:0] cfgTseg2 = 3'h1;
  logic [`CBT_ACC_W-1:0] cfgAccCtrl = 2'h0;
  logic [31:0] cfgAccCode = 32'h0, cfgAccMask = 32'hffffffff, rxId = 32'h0;
  logic [7:0] rxFlagCond = 8'h00, rxFlagData = 8'h00, rxIrqEnable = 8'h01;
  logic [2:0] txFlagCond = 3'h0, txFlagData = 3'h0, txIrqEnable = 3'h4;
  logic rxFlagWrite = 1'b0, txFlagWrite = 1'b0, lowPower = 1'b0, wakeupClear = 1'b0;
  logic rxIdValid = 1'b0;
  logic canRx, canTx, initModeAcknowledge, sleepAcknowledge, busIdle;
  logic rxIrq, txIrq, wakeupIrq, idHit, sampleOut;
  logic [7:0] receiverFlagReg;
  logic [2:0] transmitterFlagReg, idHitIdx;
  int n_errors = 0, n_checks = 0;

  cbt_top dut (.*);
  cbt_bus_node node (.canTx(canTx), .domReq(domReq), .canRx(canRx));

  always #5 clk = ~clk;
  // bus clock source at half the system rate
  always @(negedge clk) busTick <= ~busTick;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // bounded wait: 0 init ack up, 1 init ack down, 2 sleep ack up
  task automatic wt(input int k, output int n);
    n = 0;
    while (n < 2000 && !(k == 0 ? initModeAcknowledge === 1'b1 :
        k == 1 ? initModeAcknowledge === 1'b0 : sleepAcknowledge === 1'b1)) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      n_errors++;
      $display("ERROR wait %0d expected done seen stuck", k);
      tally_and_finish;
    end
  endtask

  task automatic cfg(input logic [5:0] p, input logic [3:0] t1, input logic [2:0] t2,
      input logic src, input logic [1:0] m, input logic [31:0] code);
    cfgWrite = 1'b1;
    cfgPresc = p;
    cfgTseg1 = t1;
    cfgTseg2 = t2;
    clkSrcBus = src;
    cfgAccCtrl = m;
    cfgAccCode = code;
    cfgAccMask = 32'h0000000f;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask

  // one identifier through the filter; the hit pulse stands one cycle
  task automatic idt(input logic [31:0] id, input logic hit, input logic [2:0] idx);
    rxId = id;
    rxIdValid = 1'b1;
    @(negedge clk);
    rxIdValid = 1'b0;
    chk("idHit", hit, idHit);
    if (hit) chk("idHitIdx", idx, idHitIdx);
    @(negedge clk);
  endtask

  initial begin
    int n, bc;
    static logic [37:0] flt [7] = '{{2'h3, 32'h11223344, 1'b0, 3'h0},
      {2'h1, 32'h334a0000, 1'b1, 3'h0}, {2'h1, 32'h11220000, 1'b1, 3'h1},
      {2'h2, 32'h33000000, 1'b1, 3'h1}, {2'h2, 32'h4b000000, 1'b1, 3'h0},
      {2'h0, 32'h11223354, 1'b0, 3'h0}, {2'h0, 32'h1122334b, 1'b1, 3'h0}};
    static logic [24:0] ft [7] = '{{8'h07, 1'b0, 8'h00, 8'h07}, {8'h01, 1'b1, 8'h07, 8'h01},
      {8'h00, 1'b1, 8'h00, 8'h01}, {8'h00, 1'b1, 8'h01, 8'h00},
      {8'h04, 1'b0, 8'h00, 8'h04}, {8'h00, 1'b1, 8'h03, 8'h04},
      {8'h00, 1'b1, 8'h04, 8'h00}};
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk("initAck", 1, initModeAcknowledge);
    chk("sleepAck", 0, sleepAcknowledge);
    chk("canTx", 1, canTx);
    chk("flags", 0, {receiverFlagReg, transmitterFlagReg, rxIrq, txIrq, wakeupIrq});
    $display("test reset done");
    moduleEnableBit = 1'b1;
    // shortest and longest segments; both give two clocks per quantum
    for (int i = 0; i < 2; i++) begin
      if (i == 0) cfg(6'h01, 4'h3, 3'h1, 1'b0, 2'h0, 32'h0);
      else cfg(6'h00, 4'hf, 3'h7, 1'b1, 2'h0, 32'h0);
      bc = (i == 0) ? 2 * (1 + 4 + 2) : 2 * (1 + 16 + 8);
      initModeRequest = 1'b0;
      wt(1, n);
      sleepRequest = 1'b1;
      wt(2, n);
      chk("busIdle", 1, busIdle);
      chk("sampleOut", 1, sampleOut);
      chk("idle time", 1, n >= 10 * bc && n <= 11 * bc + 8);
      initModeRequest = 1'b1;
      wt(0, n);
      chk("init wait", 1, n);
      $display("test bit timing %0d done", i);
      sleepRequest = 1'b0;
    end
    foreach (flt[j]) begin
      cfg(6'h00, 4'h3, 3'h1, 1'b0, flt[j][37:36], 32'h11223344);
      idt(flt[j][35:4], flt[j][3], flt[j][2:0]);
    end
    initModeRequest = 1'b0;
    wt(1, n);
    sleepRequest = 1'b0;
    cfg(6'h00, 4'h3, 3'h1, 1'b0, 2'h3, 32'h0);
    idt(32'h1122334b, 1'b1, 3'h0);
    $display("test filter done");
    foreach (ft[j]) begin
      {rxFlagCond, rxFlagWrite, rxFlagData} = ft[j][24:8];
      txFlagCond = rxFlagCond[2:0];
      txFlagWrite = rxFlagWrite;
      txFlagData = rxFlagData[2:0];
      @(negedge clk);
      chk("rx flags", ft[j][7:0], receiverFlagReg);
      chk("tx flags", ft[j][2:0], transmitterFlagReg);
      chk("rxIrq", |(ft[j][7:0] & rxIrqEnable), rxIrq);
      chk("txIrq", |(ft[j][2:0] & txIrqEnable), txIrq);
    end
    rxFlagWrite = 1'b0;
    txFlagWrite = 1'b0;
    $display("test flags done");
    sleepRequest = 1'b1;
    wt(2, n);
    wakeupEnable = 1'b1;
    // first pass has the wake interrupt disabled, so it must stay quiet
    for (int k = 0; k < 2; k++) begin
      wakeupInterruptEnable = k[0];
      @(negedge clk);
      lowPower = 1'b1;
      repeat (2) @(negedge clk);
      domReq = 1'b1;
      repeat (5) @(negedge clk);
      chk("wakeupIrq", k, wakeupIrq);
      domReq = 1'b0;
      lowPower = 1'b0;
      repeat (4) @(negedge clk);
      wakeupClear = 1'b1;
      @(negedge clk);
      wakeupClear = 1'b0;
      @(negedge clk);
      chk("wake clear", 0, wakeupIrq);
    end
    $display("test wake-up done");
    tally_and_finish;
  end
endmodule
